/* agen_pkg.sv */
// Package with constants for address generation and loop control
package agen_pkg;

  // Address widths
  localparam int ADDR_W      = 16;
  localparam int PAGE_W      = 9;
  localparam int OFFS_W      = 7;
  localparam int SEL_W       = 3;
  localparam int NUM_AUX     = 8;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [8:0]  RST_PAGE = 9'h000;
  localparam logic [2:0]  RST_SEL  = 3'h0;

  // Circular control register field positions
  localparam int CIRC_EN1_BIT  = 3;
  localparam int CIRC_EN2_BIT  = 7;
  localparam int CIRC_AR1_LSB  = 0;
  localparam int CIRC_AR2_LSB  = 4;

  // Memory-mapped page zero value
  localparam logic [8:0] PAGE_ZERO = 9'h000;

  // Operand addressing modes
  typedef enum logic [2:0] {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_SHORT_IMM,
    MODE_LONG_IMM,
    MODE_REGISTER,
    MODE_MMAP
  } addr_mode_t;

  // Indirect post-modification forms
  typedef enum logic [2:0] {
    MOD_NONE,
    MOD_INC,
    MOD_DEC,
    MOD_ADD_IDX,
    MOD_SUB_IDX,
    MOD_REV_INC,
    MOD_REV_DEC
  } post_mod_t;

endpackage

/* addr_gen_and_loop_control.sv */
// Operand address generator with single and block repeat sequencing
`timescale 1ns/1ps

// What this block does
// - Direct mode address is page pointer above seven instruction offset bits.
// - Indirect address comes from pointer register chosen by select pointer.
// - Seven indirect forms: inc, dec, add index, sub index, none, reversed inc/dec.
// - Pointer math same cycle; pointer and select update after address use.
// - Short immediate from instruction bits; long immediate from second word.
// - Memory-mapped access always lands on data page zero.
// - Two independent circular buffers wrap pointer to start on increment at end.
// - Circular mode uses start, end per buffer and shared control register.
// - Repeat counter loaded with N runs next instruction N plus one times.
// - Repeat counter loaded only by repeat ops, cleared on reset.
// - Clearing repeat zeroes accumulator and product before first execution.
// - All interrupts masked from repeat decode until loop completes.
// - Bus hold requests still honoured during a single repeat loop.
// - Repeated instructions retire one iteration per cycle.
// - Block repeat loads start with next address, end with long operand.
// - Block repeat sets the loop active flag in mode status.
// - At PC equals end: count above zero decrements and reloads, else exits.
// - Clearing loop active flag ends loop after current pass.
// - Branches, calls and interrupts inside a loop do not cancel it.
module addr_gen_and_loop_control (
  input  wire logic        I_SYS_CLK,        // Core machine clock
  input  wire logic        I_RESET,          // Synchronous reset, active high
  input  wire logic        I_CLK_EN,         // Freezes all state when low
  input  wire logic        I_OP_VALID,       // Instruction operand step this cycle
  input  wire logic [2:0]  I_ADDR_MODE,      // Addressing mode, addr_mode_t
  input  wire logic [15:0] I_INSTR_WORD,     // First instruction word
  input  wire logic [15:0] I_LONG_WORD,      // Second instruction word
  input  wire logic [2:0]  I_POST_MOD,       // Indirect post-modify form
  input  wire logic        I_SEL_LOAD,       // Load select pointer after use
  input  wire logic [2:0]  I_SEL_NEXT,       // New select pointer value
  input  wire logic [15:0] I_REG_OPERAND,    // Operand from a CPU register
  input  wire logic        I_PAGE_WR,        // Write data page pointer
  input  wire logic [8:0]  I_PAGE_DATA,      // Data page pointer value
  input  wire logic        I_AUX_WR,         // Write a pointer register
  input  wire logic [2:0]  I_AUX_IDX,        // Pointer register to write
  input  wire logic [15:0] I_AUX_DATA,       // Pointer register value
  input  wire logic        I_CIRC_WR,        // Write a circular register
  input  wire logic [2:0]  I_CIRC_IDX,       // 0 st1,1 end1,2 st2,3 end2,4 ctl
  input  wire logic [15:0] I_CIRC_DATA,      // Circular register value
  input  wire logic        I_RPT_SINGLE,     // Repeat single op decoded
  input  wire logic        I_RPT_CLEAR,      // Repeat clear op decoded
  input  wire logic [15:0] I_RPT_COUNT,      // Repeat count operand N
  input  wire logic        I_RPT_STEP,       // One repeated execution retired
  input  wire logic        I_HOLD_REQ,       // External bus hold request
  input  wire logic        I_CNT_WR,         // Write loop count register
  input  wire logic [15:0] I_CNT_DATA,       // Loop count value
  input  wire logic        I_BLK_RPT,        // Repeat block op executed
  input  wire logic [15:0] I_PC_NEXT_INSTR,  // Address after repeat block op
  input  wire logic        I_PC_UPDATE,      // Program counter advance
  input  wire logic [15:0] I_PC,             // Current program counter
  input  wire logic        I_FLAG_WR,        // Software writes loop active flag
  input  wire logic        I_FLAG_DATA,      // Loop active flag value
  output logic      [15:0] O_DATA_ADDR,      // Data address
  output logic      [15:0] O_OPERAND,        // Immediate or register operand
  output logic             O_ADDR_VALID,     // Address or operand valid
  output logic             O_IRQ_MASK,       // All interrupts masked
  output logic             O_HOLD_ACK,       // Hold granted
  output logic             O_CLR_ACC_PROD,   // Zero accumulator and product
  output logic             O_RPT_BUSY,       // Single repeat running
  output logic      [15:0] O_RPT_COUNTER,    // Single repeat counter
  output logic             O_LOOP_ACTIVE,    // Loop active flag
  output logic      [15:0] O_LOOP_COUNT,     // Loop count register
  output logic      [15:0] O_LOOP_START,     // Loop start address
  output logic      [15:0] O_LOOP_END,       // Loop end address
  output logic             O_PC_LOAD,        // Load PC with loop start
  output logic      [15:0] O_PC_TARGET       // PC reload value
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [8:0]       data_page_pointer;
    logic [7:0][15:0] aux_pointer_regs;
    logic [2:0]       aux_select_pointer;
    logic [15:0]      circ_start1;
    logic [15:0]      circ_end1;
    logic [15:0]      circ_start2;
    logic [15:0]      circ_end2;
    logic [15:0]      circ_ctrl;
    logic [15:0]      single_repeat_counter;
    logic             rpt_busy;
    logic [15:0]      loop_start_address;
    logic [15:0]      loop_end_address;
    logic [15:0]      loop_count_register;
    logic             loop_active_flag;
    logic [15:0]      data_addr;
    logic [15:0]      operand;
    logic             addr_valid;
    logic             clr_acc_prod;
    logic             hold_ack;
    logic             pc_load;
    logic [15:0]      pc_target;
  } state_t;

  // Every register lives in one packed word so that reset and the
  // clock enable treat the whole block alike
  // Registered state and its next value
  state_t st_r;
  state_t st_nxt;

  // Pointer chosen by the select pointer, and the index pointer
  logic [15:0] cur_ptr;
  logic [15:0] idx;

  // Pointer value written back after the address has been used
  logic [15:0] mod_ptr;

  // Operands in reversed bit order for reversed-carry arithmetic
  logic [15:0] rev_a;
  logic [15:0] rev_b;

  // Buffer one wrapped, so buffer two must not wrap as well
  logic        circ_hit;

  // Bit reversal of a word
  // Adding reversed words lets the carry run from the top bit downward,
  // which steps a transform pointer through reversed order
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // ****************************************************************
  // Pointer arithmetic
  // ****************************************************************
  always_comb begin
    cur_ptr = st_r.aux_pointer_regs[st_r.aux_select_pointer];
    idx     = st_r.aux_pointer_regs[0];
    rev_a   = rev16(cur_ptr);
    rev_b   = rev16(idx);
    unique case (agen_pkg::post_mod_t'(I_POST_MOD))
      agen_pkg::MOD_INC:     mod_ptr = cur_ptr + 16'h0001;
      agen_pkg::MOD_DEC:     mod_ptr = cur_ptr - 16'h0001;
      agen_pkg::MOD_ADD_IDX: mod_ptr = cur_ptr + idx;
      agen_pkg::MOD_SUB_IDX: mod_ptr = cur_ptr - idx;
      agen_pkg::MOD_REV_INC: mod_ptr = rev16(rev_a + rev_b);
      agen_pkg::MOD_REV_DEC: mod_ptr = rev16(rev_a - rev_b);
      default:               mod_ptr = cur_ptr;
    endcase
    // Circular wrap on either enabled buffer
    // Wrap only on increment at the end register; a buffer set up with
    // its start above its end still wraps, since the start is never compared
    circ_hit = 1'b0;
    if (st_r.circ_ctrl[agen_pkg::CIRC_EN1_BIT] &&
        st_r.circ_ctrl[agen_pkg::CIRC_AR1_LSB +: 3] == st_r.aux_select_pointer &&
        cur_ptr == st_r.circ_end1 && I_POST_MOD == 3'(agen_pkg::MOD_INC)) begin
      mod_ptr  = st_r.circ_start1;
      circ_hit = 1'b1;
    end
    if (!circ_hit && st_r.circ_ctrl[agen_pkg::CIRC_EN2_BIT] &&
        st_r.circ_ctrl[agen_pkg::CIRC_AR2_LSB +: 3] == st_r.aux_select_pointer &&
        cur_ptr == st_r.circ_end2 && I_POST_MOD == 3'(agen_pkg::MOD_INC)) begin
      mod_ptr = st_r.circ_start2;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt              = st_r;
    st_nxt.addr_valid   = 1'b0;
    st_nxt.clr_acc_prod = 1'b0;
    st_nxt.pc_load      = 1'b0;
    st_nxt.hold_ack     = I_HOLD_REQ;
    // Register writes
    // Software writes land at this edge; an operand step in the same cycle
    // that modifies the same pointer wins, since it is applied later
    if (I_PAGE_WR) begin
      st_nxt.data_page_pointer = I_PAGE_DATA;
    end
    // Pointer register write by index
    if (I_AUX_WR) begin
      st_nxt.aux_pointer_regs[I_AUX_IDX] = I_AUX_DATA;
    end
    // Circular registers: two starts, two ends, then the shared control
    if (I_CIRC_WR) begin
      unique case (I_CIRC_IDX)
        3'h0:    st_nxt.circ_start1 = I_CIRC_DATA;
        3'h1:    st_nxt.circ_end1   = I_CIRC_DATA;
        3'h2:    st_nxt.circ_start2 = I_CIRC_DATA;
        3'h3:    st_nxt.circ_end2   = I_CIRC_DATA;
        default: st_nxt.circ_ctrl   = I_CIRC_DATA;
      endcase
    end
    // Operand address formation
    // Address and operand hold their last value between steps;
    // only the valid pulse drops back to zero
    if (I_OP_VALID) begin
      st_nxt.addr_valid = 1'b1;
      unique case (agen_pkg::addr_mode_t'(I_ADDR_MODE))
        agen_pkg::MODE_DIRECT:
          st_nxt.data_addr = {st_r.data_page_pointer, I_INSTR_WORD[6:0]};
        agen_pkg::MODE_INDIRECT: begin
          st_nxt.data_addr = cur_ptr;
          st_nxt.aux_pointer_regs[st_r.aux_select_pointer] = mod_ptr;
          if (I_SEL_LOAD) begin
            st_nxt.aux_select_pointer = I_SEL_NEXT;
          end
        end
        agen_pkg::MODE_SHORT_IMM:
          st_nxt.operand = {8'h00, I_INSTR_WORD[7:0]};
        agen_pkg::MODE_LONG_IMM:
          st_nxt.operand = I_LONG_WORD;
        agen_pkg::MODE_REGISTER:
          st_nxt.operand = I_REG_OPERAND;
        agen_pkg::MODE_MMAP:
          st_nxt.data_addr = {agen_pkg::PAGE_ZERO, I_INSTR_WORD[6:0]};
        default:
          st_nxt.addr_valid = 1'b0;
      endcase
    end
    // Single repeat: one retired execution per cycle
    // A new repeat load beats a step in the same cycle; the step seen
    // with the counter at zero ends the loop and lifts the mask
    if (I_RPT_SINGLE || I_RPT_CLEAR) begin
      st_nxt.single_repeat_counter = I_RPT_COUNT;
      st_nxt.rpt_busy              = 1'b1;
      st_nxt.clr_acc_prod          = I_RPT_CLEAR;
    end else if (st_r.rpt_busy && I_RPT_STEP) begin
      if (st_r.single_repeat_counter == agen_pkg::RST_WORD) begin
        st_nxt.rpt_busy = 1'b0;
      end else begin
        st_nxt.single_repeat_counter = st_r.single_repeat_counter - 16'h0001;
      end
    end
    // Block repeat
    // A repeat block op beats the end compare, and a software flag clear
    // in the same cycle as the compare suppresses the reload; a jump out
    // of the loop leaves the flag set, so looping resumes on return
    // Loop count is loaded by software before the repeat block op
    if (I_CNT_WR) begin
      st_nxt.loop_count_register = I_CNT_DATA;
    end
    // Software may set or clear the loop active flag at any time
    if (I_FLAG_WR) begin
      st_nxt.loop_active_flag = I_FLAG_DATA;
    end
    if (I_BLK_RPT) begin
      st_nxt.loop_start_address = I_PC_NEXT_INSTR;
      st_nxt.loop_end_address   = I_LONG_WORD;
      st_nxt.loop_active_flag   = 1'b1;
    end else if (I_PC_UPDATE && st_r.loop_active_flag &&
                 !(I_FLAG_WR && !I_FLAG_DATA) &&
                 I_PC == st_r.loop_end_address) begin
      if (st_r.loop_count_register != agen_pkg::RST_WORD) begin
        st_nxt.loop_count_register = st_r.loop_count_register - 16'h0001;
        st_nxt.pc_load             = 1'b1;
        st_nxt.pc_target           = st_r.loop_start_address;
      end else begin
        st_nxt.loop_active_flag = 1'b0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Clock enable low freezes every flip-flop; reset wins over it
  // and clears all state, repeat counters and loop flag included
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      st_r <= '0;
    end else if (I_CLK_EN) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Outputs straight from state flip-flops
  // Operand side
  assign O_DATA_ADDR    = st_r.data_addr;
  assign O_OPERAND      = st_r.operand;
  assign O_ADDR_VALID   = st_r.addr_valid;

  // Single repeat side
  assign O_IRQ_MASK     = st_r.rpt_busy;
  assign O_HOLD_ACK     = st_r.hold_ack;
  assign O_CLR_ACC_PROD = st_r.clr_acc_prod;
  assign O_RPT_BUSY     = st_r.rpt_busy;
  assign O_RPT_COUNTER  = st_r.single_repeat_counter;

  // Block repeat side
  assign O_LOOP_ACTIVE  = st_r.loop_active_flag;
  assign O_LOOP_COUNT   = st_r.loop_count_register;
  assign O_LOOP_START   = st_r.loop_start_address;
  assign O_LOOP_END     = st_r.loop_end_address;
  assign O_PC_LOAD      = st_r.pc_load;
  assign O_PC_TARGET    = st_r.pc_target;

endmodule

/* addr_gen_and_loop_control_assertions.sv */
// Concurrent checks on the ports of the address generator and loop sequencer
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module addr_gen_and_loop_control_checker (
  input wire logic        I_SYS_CLK, I_RESET, I_CLK_EN, I_OP_VALID,  // Clock, reset, step
  input wire logic        I_RPT_SINGLE, I_RPT_CLEAR, I_RPT_STEP,     // Single repeat
  input wire logic        I_HOLD_REQ, I_CNT_WR, I_BLK_RPT,           // Hold and block
  input wire logic        I_PC_UPDATE, I_FLAG_WR,                    // Program counter
  input wire logic [2:0]  I_ADDR_MODE,                               // Addressing mode
  input wire logic [15:0] I_INSTR_WORD, I_LONG_WORD, I_RPT_COUNT,    // Words
  input wire logic [15:0] I_PC_NEXT_INSTR, I_PC,                     // Addresses
  input wire logic        O_ADDR_VALID, O_IRQ_MASK, O_HOLD_ACK,      // Flags
  input wire logic        O_CLR_ACC_PROD, O_RPT_BUSY, O_LOOP_ACTIVE, // Flags
  input wire logic        O_PC_LOAD,                                 // Reload pulse
  input wire logic [15:0] O_DATA_ADDR, O_OPERAND, O_RPT_COUNTER,     // Values
  input wire logic [15:0] O_LOOP_COUNT, O_LOOP_START, O_LOOP_END,    // Loop registers
  input wire logic [15:0] O_PC_TARGET                                // Reload value
);
  // One clock domain, synchronous reset aborts every check
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RESET);
  // Operand forming
  a_direct_addr: assert property (I_CLK_EN && I_OP_VALID && I_ADDR_MODE == 3'h0 |=>
    O_ADDR_VALID && O_DATA_ADDR[6:0] == $past(I_INSTR_WORD[6:0])) else $error("direct offset");
  a_mmap_page: assert property (I_CLK_EN && I_OP_VALID && I_ADDR_MODE == 3'h5 |=>
    O_DATA_ADDR == {9'h000, $past(I_INSTR_WORD[6:0])}) else $error("page zero address");
  a_long_imm: assert property (I_CLK_EN && I_OP_VALID && I_ADDR_MODE == 3'h3 |=>
    O_OPERAND == $past(I_LONG_WORD)) else $error("long operand");
  // Single repeat
  a_rpt_load: assert property (I_CLK_EN && (I_RPT_SINGLE || I_RPT_CLEAR) |=>
    O_RPT_BUSY && O_IRQ_MASK && O_RPT_COUNTER == $past(I_RPT_COUNT)) else $error("repeat load");
  a_clear_pulse: assert property (I_CLK_EN && I_RPT_CLEAR |=> O_CLR_ACC_PROD)
    else $error("no clear pulse");
  a_mask_busy: assert property (O_RPT_BUSY |-> O_IRQ_MASK) else $error("unmasked");
  a_rpt_done: assert property (I_CLK_EN && O_RPT_BUSY && I_RPT_STEP &&
    O_RPT_COUNTER == 16'h0000 && !I_RPT_SINGLE && !I_RPT_CLEAR |=> !O_RPT_BUSY && !O_IRQ_MASK)
    else $error("repeat end");
  a_hold_grant: assert property (I_CLK_EN && I_HOLD_REQ && O_RPT_BUSY |=> O_HOLD_ACK)
    else $error("hold ignored");
  // Block repeat
  a_blk_load: assert property (I_CLK_EN && I_BLK_RPT |=> O_LOOP_ACTIVE &&
    O_LOOP_START == $past(I_PC_NEXT_INSTR) && O_LOOP_END == $past(I_LONG_WORD))
    else $error("block load");
  a_loop_reload: assert property (I_CLK_EN && I_PC_UPDATE && O_LOOP_ACTIVE &&
    I_PC == O_LOOP_END && O_LOOP_COUNT != 16'h0000 && !I_BLK_RPT && !I_FLAG_WR && !I_CNT_WR
    |=> O_PC_LOAD && O_PC_TARGET == O_LOOP_START &&
    O_LOOP_COUNT == $past(O_LOOP_COUNT) - 16'h0001) else $error("loop reload");
  a_loop_exit: assert property (I_CLK_EN && I_PC_UPDATE && O_LOOP_ACTIVE &&
    I_PC == O_LOOP_END && O_LOOP_COUNT == 16'h0000 && !I_BLK_RPT
    |=> !O_LOOP_ACTIVE && !O_PC_LOAD) else $error("loop exit");
endmodule

bind addr_gen_and_loop_control addr_gen_and_loop_control_checker chk_u (.*);

/* test_addr_gen_and_loop_control.sv */
// Self-checking bench for the address generator and loop sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_addr_gen_and_loop_control;
  // ****************************************
  // Stimulus signals, named as the ports
  // ****************************************
  logic I_SYS_CLK = 0, I_RESET = 1, I_CLK_EN = 1, I_OP_VALID = 0, I_SEL_LOAD = 0;
  logic I_RPT_SINGLE = 0, I_RPT_CLEAR = 0, I_RPT_STEP = 0, I_HOLD_REQ = 0, I_BLK_RPT = 0;
  logic I_PC_UPDATE = 0, I_FLAG_WR = 0, I_FLAG_DATA = 0;
  logic [2:0] I_ADDR_MODE = '0, I_POST_MOD = '0, I_SEL_NEXT = '0, wi = '0;
  logic [3:0] st = '0;
  logic [15:0] I_INSTR_WORD = '0, I_PC_NEXT_INSTR = '0, I_PC = '0, wd = '0;
  wire I_PAGE_WR = st[0], I_AUX_WR = st[1], I_CIRC_WR = st[2], I_CNT_WR = st[3];
  wire [2:0] I_AUX_IDX = wi, I_CIRC_IDX = wi;
  wire [8:0] I_PAGE_DATA = wd[8:0];
  wire [15:0] I_AUX_DATA = wd, I_CIRC_DATA = wd, I_CNT_DATA = wd, I_LONG_WORD = wd;
  wire [15:0] I_RPT_COUNT = wd, I_REG_OPERAND = wd;
  logic O_ADDR_VALID, O_IRQ_MASK, O_HOLD_ACK, O_CLR_ACC_PROD, O_RPT_BUSY, O_LOOP_ACTIVE;
  logic O_PC_LOAD;
  logic [15:0] O_DATA_ADDR, O_OPERAND, O_RPT_COUNTER, O_LOOP_COUNT, O_LOOP_START;
  logic [15:0] O_LOOP_END, O_PC_TARGET;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [2:0] mods [9] = '{1, 2, 3, 4, 0, 5, 5, 6, 0};
  logic [15:0] exps [9] = '{16'h0100, 16'h0101, 16'h0100, 16'h0104, 16'h0100,
                            16'h0100, 16'h0104, 16'h0102, 16'h0104};
  addr_gen_and_loop_control dut_u (.*);
  // Clock and cycle ceiling
  always #10 I_SYS_CLK = ~I_SYS_CLK;
  always @(posedge I_SYS_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Register write: 0 page, 1 pointer, 2 circular, 3 loop count
  task automatic wr(input int k, input logic [2:0] i, input logic [15:0] d);
    st = 4'(1 << k);
    wi = i;
    wd = d;
    @(negedge I_SYS_CLK);
    st = '0;
    @(negedge I_SYS_CLK);
  endtask
  // Operand step, checked one cycle after it is taken
  task automatic op(input logic [2:0] m, pm, input logic sl, input logic [2:0] sn,
                    input logic [15:0] iw, e);
    I_OP_VALID = 1;
    I_ADDR_MODE = m;
    I_POST_MOD = pm;
    I_SEL_LOAD = sl;
    I_SEL_NEXT = sn;
    I_INSTR_WORD = iw;
    @(negedge I_SYS_CLK);
    `CHK("valid", 1'b1, O_ADDR_VALID)
    `CHK("addr", e, (m == 3'h2 || m == 3'h3 || m == 3'h4) ? O_OPERAND : O_DATA_ADDR)
    I_OP_VALID = 0;
    I_SEL_LOAD = 0;
    @(negedge I_SYS_CLK);
  endtask
  // Program counter update, reload pulse expected or not
  task automatic pc(input logic [15:0] p, input logic e);
    I_PC = p;
    I_PC_UPDATE = 1;
    @(negedge I_SYS_CLK);
    `CHK("pcload", e, O_PC_LOAD)
    if (e) `CHK("target", 16'h0040, O_PC_TARGET)
    I_PC_UPDATE = 0;
    @(negedge I_SYS_CLK);
  endtask
  // Block repeat issue with start 0x0040 and end 0x0045
  task automatic blk();
    I_PC_NEXT_INSTR = 16'h0040;
    wd = 16'h0045;
    I_BLK_RPT = 1;
    @(negedge I_SYS_CLK);
    I_BLK_RPT = 0;
    @(negedge I_SYS_CLK);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge I_SYS_CLK);
    I_RESET = 0;
    `CHK("rptcnt", 16'h0000, O_RPT_COUNTER)
    `CHK("active", 1'b0, O_LOOP_ACTIVE)
    wr(0, 0, 16'h01A5);
    I_CLK_EN = 0;
    wr(0, 0, 16'h0055);
    I_CLK_EN = 1;
    op(0, 0, 0, 0, 16'h0FF3, 16'hD2F3);
    op(5, 0, 0, 0, 16'h0FF3, 16'h0073);
    op(2, 0, 0, 0, 16'h12AB, 16'h00AB);
    wd = 16'h5A5A;
    op(3, 0, 0, 0, 16'h0000, 16'h5A5A);
    op(4, 0, 0, 0, 16'h0000, 16'h5A5A);
    wr(1, 0, 16'h0004);
    wr(1, 3, 16'h0100);
    op(1, 0, 1, 3, 16'h0000, 16'h0004);
    for (int i = 0; i < 9; i++) op(1, mods[i], 0, 0, 16'h0000, exps[i]);
    wr(2, 0, 16'h0200);
    wr(2, 1, 16'h0202);
    wr(2, 2, 16'h0300);
    wr(2, 3, 16'h0301);
    wr(2, 4, 16'h00DB);
    wr(1, 3, 16'h0200);
    wr(1, 5, 16'h0300);
    for (int i = 0; i < 4; i++) op(1, 1, 0, 0, 16'h0000, 16'h0200 + 16'(i % 3));
    op(1, 1, 1, 5, 16'h0000, 16'h0201);
    for (int i = 0; i < 3; i++) op(1, 1, 0, 0, 16'h0000, 16'h0300 + 16'(i % 2));
    // Clearing repeat then plain repeat, with a hold request standing
    for (int k = 0; k < 2; k++) begin
      I_RPT_CLEAR = (k == 0);
      I_RPT_SINGLE = (k == 1);
      wd = (k == 0) ? 16'h0002 : 16'h0000;
      I_HOLD_REQ = 1;
      @(negedge I_SYS_CLK);
      I_RPT_CLEAR = 0;
      I_RPT_SINGLE = 0;
      `CHK("clear", (k == 0), O_CLR_ACC_PROD)
      `CHK("mask", 1'b1, O_IRQ_MASK)
      `CHK("count", wd, O_RPT_COUNTER)
      I_RPT_STEP = 1;
      for (int s = 0; s <= wd; s++) begin
        @(negedge I_SYS_CLK);
        `CHK("busy", (s < wd), O_RPT_BUSY)
        `CHK("holdack", 1'b1, O_HOLD_ACK)
      end
      I_RPT_STEP = 0;
      I_HOLD_REQ = 0;
      @(negedge I_SYS_CLK);
    end
    wr(3, 0, 16'h0001);
    blk();
    `CHK("active", 1'b1, O_LOOP_ACTIVE)
    `CHK("start", 16'h0040, O_LOOP_START)
    `CHK("end", 16'h0045, O_LOOP_END)
    pc(16'h0100, 1'b0);
    `CHK("active", 1'b1, O_LOOP_ACTIVE)
    pc(16'h0045, 1'b1);
    `CHK("loopcnt", 16'h0000, O_LOOP_COUNT)
    pc(16'h0045, 1'b0);
    `CHK("active", 1'b0, O_LOOP_ACTIVE)
    wr(3, 0, 16'h0003);
    blk();
    I_FLAG_WR = 1;
    @(negedge I_SYS_CLK);
    I_FLAG_WR = 0;
    pc(16'h0045, 1'b0);
    `CHK("active", 1'b0, O_LOOP_ACTIVE)
    // Reset in mid-run with both loop kinds active
    blk();
    I_RPT_SINGLE = 1;
    @(negedge I_SYS_CLK);
    I_RPT_SINGLE = 0;
    I_RESET = 1;
    @(negedge I_SYS_CLK);
    I_RESET = 0;
    `CHK("active", 1'b0, O_LOOP_ACTIVE)
    `CHK("loopcnt", 16'h0000, O_LOOP_COUNT)
    `CHK("rptcnt", 16'h0000, O_RPT_COUNTER)
    print_verdict();
  end
endmodule
